// ===== hdl/flash_cmd_device.sv
// Flash command interpreter for quad page write and the array wipe commands.
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_device #(
    parameter int PROG_CYCLES = flash_cmd_pkg::PROG_CYCLES_DEF,
    parameter int ERASE_CYCLES = flash_cmd_pkg::ERASE_CYCLES_DEF
) (
    // Clock and reset.
    input wire logic CLK_SYS,
    input wire logic RESETN,
    // Serial link.
    spi_link_if.dev LINK,
    // Configuration.
    input wire logic QUAD_ENABLE,
    input wire logic ADDR_LONG_CFG,
    input wire logic FOUR_LANE_MODE,
    // Protection answers for TARGET_ADDR.
    input wire logic PROT_SECTOR,
    input wire logic PROT_HALF,
    input wire logic PROT_BLOCK,
    input wire logic PROT_ANY,
    input wire logic ERR_CLEAR,
    // Status.
    output logic WRITE_UNLOCK_LATCH,
    output logic OPERATION_BUSY_FLAG,
    output logic ERASE_ERR,
    // Operation launch.
    output logic [31:0] TARGET_ADDR,
    output logic [31:0] OP_ADDR,
    output flash_cmd_pkg::op_kind_t OP_KIND,
    output logic OP_START,
    // Page buffer write port.
    output logic PB_WE,
    output logic [7:0] PB_OFS,
    output logic [7:0] PB_DATA
);
    import flash_cmd_pkg::*;

    function automatic op_kind_t decode_kind(input logic [7:0] op);
        case (op)
            OP_QUAD_PAGE_WRITE, OP_QUAD_PAGE_WRITE_LONG: decode_kind = KIND_PROG;
            OP_SECTOR_WIPE, OP_SECTOR_WIPE_LONG: decode_kind = KIND_SECTOR;
            OP_HALF_BLOCK_WIPE, OP_HALF_BLOCK_WIPE_LONG: decode_kind = KIND_HALF;
            OP_BLOCK_WIPE, OP_BLOCK_WIPE_LONG: decode_kind = KIND_BLOCK;
            OP_CHIP_WIPE_A, OP_CHIP_WIPE_B: decode_kind = KIND_CHIP;
            default: decode_kind = KIND_NONE;
        endcase
    endfunction : decode_kind

    function automatic logic [31:0] region_base(input op_kind_t k, input logic [31:0] a);
        case (k)
            KIND_SECTOR: region_base = a & SECTOR_MASK;
            KIND_HALF: region_base = a & HALF_MASK;
            KIND_BLOCK: region_base = a & BLOCK_MASK;
            KIND_CHIP: region_base = 32'h0000_0000;
            default: region_base = a;
        endcase
    endfunction : region_base

    logic [2:0] sck_s_r;
    logic [2:0] cs_s_r;
    logic [3:0] io_m_r;
    logic [3:0] io_s_r;
    logic [12:0] cnt_r;
    logic [7:0] sh_r;
    logic [7:0] op_r;
    logic [31:0] addr_r;
    logic wel_r;
    logic busy_r;
    logic err_r;
    logic [BUSY_CNT_W-1:0] busy_cnt_r;
    logic start_r;
    op_kind_t kind_r;
    logic [31:0] op_addr_r;
    logic pb_we_r;
    logic [7:0] pb_ofs_r;
    logic [7:0] pb_data_r;

    // Pins cross two flops before any logic reads them.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            sck_s_r <= 3'h0;
            cs_s_r <= 3'h7;
            io_m_r <= 4'hF;
            io_s_r <= 4'hF;
        end else begin
            sck_s_r <= {sck_s_r[1:0], LINK.sck};
            cs_s_r <= {cs_s_r[1:0], LINK.cs_n};
            io_m_r <= LINK.io;
            io_s_r <= io_m_r;
        end
    end

    wire sck_rise = sck_s_r[1] & ~sck_s_r[2];
    wire cs_low = ~cs_s_r[1];
    wire cs_rise = cs_s_r[1] & ~cs_s_r[2];

    wire op_kind_t kind = decode_kind(op_r);
    wire is_prog = (kind == KIND_PROG);
    wire is_chip = (kind == KIND_CHIP);
    wire is_addr_wipe = (kind == KIND_SECTOR) | (kind == KIND_HALF) | (kind == KIND_BLOCK);
    wire long_op = (op_r == OP_QUAD_PAGE_WRITE_LONG) | (op_r == OP_SECTOR_WIPE_LONG) |
        (op_r == OP_HALF_BLOCK_WIPE_LONG) | (op_r == OP_BLOCK_WIPE_LONG);
    wire [12:0] hdr_bits = (long_op | ADDR_LONG_CFG) ? HDR_BITS_LONG : HDR_BITS_SHORT;
    wire in_hdr = (cnt_r < hdr_bits);
    wire hdr_four = FOUR_LANE_MODE;
    // Header nibbles in four lane mode, quad page data always four lanes.
    wire lanes4 = (cnt_r < OPCODE_BITS | in_hdr) ? hdr_four : is_prog;
    wire [7:0] sh_nxt = lanes4 ? {sh_r[3:0], io_s_r} : {sh_r[6:0], io_s_r[0]};
    wire [12:0] cnt_nxt = cnt_r + (lanes4 ? 13'h004 : 13'h001);
    wire byte_done = sck_rise & cs_low & (cnt_nxt[2:0] == 3'h0);
    // Data reaches the page buffer only for a write that may be accepted.
    wire prog_ok = is_prog & QUAD_ENABLE & wel_r & ~busy_r;

    // Frame length checks taken at the chip select rise.
    wire prog_len_ok = (cnt_r >= hdr_bits + 13'h008) & (cnt_r[2:0] == 3'h0);
    wire wipe_len_ok = (cnt_r == hdr_bits);
    wire chip_len_ok = (cnt_r == OPCODE_BITS);
    wire len_ok = is_prog ? prog_len_ok : (is_chip ? chip_len_ok : wipe_len_ok);
    wire prot_hit = ((kind == KIND_SECTOR) & PROT_SECTOR) |
        ((kind == KIND_HALF) & PROT_HALF) |
        ((kind == KIND_BLOCK) & PROT_BLOCK) |
        (is_chip & PROT_ANY);
    wire frame_end = cs_rise & (cnt_r != 13'h000) & ~busy_r;
    wire write_type = is_prog | is_chip | is_addr_wipe;
    wire unlock_end = frame_end & (op_r == OP_WRITE_UNLOCK) & chip_len_ok;
    wire attempt = frame_end & write_type & len_ok & wel_r;
    wire go = attempt & ~prot_hit & (~is_prog | QUAD_ENABLE);
    wire err_set = attempt & prot_hit & ~is_prog;
    wire busy_done = busy_r & (busy_cnt_r == '0);

    // Receive shifter: opcode, address bytes, then data bytes.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            cnt_r <= 13'h000;
            sh_r <= 8'h00;
            op_r <= 8'h00;
            addr_r <= 32'h0000_0000;
        end else if (!cs_low) begin
            cnt_r <= 13'h000;
            addr_r <= 32'h0000_0000;
        end else if (sck_rise) begin
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            if (byte_done && cnt_nxt == OPCODE_BITS) begin
                op_r <= sh_nxt;
            end else if (byte_done && cnt_nxt <= hdr_bits) begin
                addr_r <= {addr_r[23:0], sh_nxt};
            end
        end
    end

    // Page buffer write strobes; the offset wraps inside the page.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            pb_we_r <= 1'b0;
            pb_ofs_r <= 8'h00;
            pb_data_r <= 8'h00;
        end else begin
            pb_we_r <= byte_done & (cnt_nxt > hdr_bits) & (cnt_r >= OPCODE_BITS) & prog_ok;
            if (byte_done && cnt_nxt == hdr_bits) begin
                pb_ofs_r <= sh_nxt;
            end else if (pb_we_r) begin
                pb_ofs_r <= pb_ofs_r + 8'h01;
            end
            if (byte_done) begin
                pb_data_r <= sh_nxt;
            end
        end
    end

    // Launch, latch and busy timing. Commands during busy are ignored.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            wel_r <= 1'b0;
            busy_r <= 1'b0;
            err_r <= 1'b0;
            busy_cnt_r <= '0;
            start_r <= 1'b0;
            kind_r <= KIND_NONE;
            op_addr_r <= 32'h0000_0000;
        end else begin
            start_r <= go;
            err_r <= err_set | (err_r & ~ERR_CLEAR);
            if (unlock_end) begin
                wel_r <= 1'b1;
            end else if (frame_end && write_type) begin
                wel_r <= 1'b0;
            end
            if (go) begin
                busy_r <= 1'b1;
                busy_cnt_r <= is_prog ? BUSY_CNT_W'(PROG_CYCLES - 1) : BUSY_CNT_W'(ERASE_CYCLES - 1);
                kind_r <= kind;
                op_addr_r <= region_base(kind, addr_r);
            end else if (busy_done) begin
                busy_r <= 1'b0;
            end else if (busy_r) begin
                busy_cnt_r <= busy_cnt_r - 1'b1;
            end
        end
    end

    assign WRITE_UNLOCK_LATCH = wel_r;
    assign OPERATION_BUSY_FLAG = busy_r;
    assign ERASE_ERR = err_r;
    assign TARGET_ADDR = addr_r;
    assign OP_ADDR = op_addr_r;
    assign OP_KIND = kind_r;
    assign OP_START = start_r;
    assign PB_WE = pb_we_r;
    assign PB_OFS = pb_ofs_r;
    assign PB_DATA = pb_data_r;
endmodule : flash_cmd_device
`default_nettype wire

// ===== hdl/flash_cmd_pkg.sv
// Shared opcodes, operation kinds, timing counts and host register map.
package flash_cmd_pkg;
    // Opcodes.
    localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
    localparam logic [7:0] OP_QUAD_PAGE_WRITE = 8'h32;
    localparam logic [7:0] OP_QUAD_PAGE_WRITE_LONG = 8'h34;
    localparam logic [7:0] OP_SECTOR_WIPE = 8'h20;
    localparam logic [7:0] OP_SECTOR_WIPE_LONG = 8'h21;
    localparam logic [7:0] OP_HALF_BLOCK_WIPE = 8'h52;
    localparam logic [7:0] OP_HALF_BLOCK_WIPE_LONG = 8'h53;
    localparam logic [7:0] OP_BLOCK_WIPE = 8'hD8;
    localparam logic [7:0] OP_BLOCK_WIPE_LONG = 8'hDC;
    localparam logic [7:0] OP_CHIP_WIPE_A = 8'h60;
    localparam logic [7:0] OP_CHIP_WIPE_B = 8'hC7;

    typedef enum logic [2:0] {
        KIND_NONE = 3'h0,
        KIND_PROG = 3'h1,
        KIND_SECTOR = 3'h2,
        KIND_HALF = 3'h3,
        KIND_BLOCK = 3'h4,
        KIND_CHIP = 3'h5
    } op_kind_t;

    // Frame lengths in bits.
    localparam logic [12:0] OPCODE_BITS = 13'h008;
    localparam logic [12:0] HDR_BITS_SHORT = 13'h020;
    localparam logic [12:0] HDR_BITS_LONG = 13'h028;

    // Region alignment masks.
    localparam logic [31:0] SECTOR_MASK = 32'hFFFF_F000;
    localparam logic [31:0] HALF_MASK = 32'hFFFF_8000;
    localparam logic [31:0] BLOCK_MASK = 32'hFFFF_0000;

    // Self-timed operation lengths.
    localparam int CLK_PERIOD_NS = 20;
    localparam int PROG_TIME_NS = 400000;
    localparam int ERASE_TIME_NS = 1000000;
    localparam int PROG_CYCLES_DEF = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ERASE_CYCLES_DEF = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_CNT_W = 24;

    // Link clock: half period in system cycles; must keep the link under this.
    localparam int SCK_MAX_MHZ = 133;
    localparam logic [2:0] SCK_HALF_CYCLES = 3'h4;

    // Host register map.
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_ADDR = 12'h004;
    localparam logic [11:0] REG_DATA = 12'h008;
    localparam logic [11:0] REG_STATUS = 12'h00C;
    localparam int CTRL_START_BIT = 8;
    localparam int CTRL_FOUR_LANE_BIT = 9;
    localparam int CTRL_ADDR_EN_BIT = 10;
    localparam int CTRL_ADDR_LONG_BIT = 11;
    localparam int CTRL_QUAD_DATA_BIT = 12;
    localparam int CTRL_NBYTES_LSB = 13;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
endpackage : flash_cmd_pkg

// ===== hdl/spi_link_if.sv
// Serial link between the host controller and the flash command device.
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
    logic sck;
    logic cs_n;
    logic [3:0] io_host_o;
    logic [3:0] io_host_oe;
    logic [3:0] io;

    // Undriven lanes float high through pull-ups.
    assign io = (io_host_o & io_host_oe) | ~io_host_oe;

    modport host (output sck, output cs_n, output io_host_o, output io_host_oe);
    modport dev (input sck, input cs_n, input io);
endinterface : spi_link_if
`default_nettype wire

// ===== hdl/flash_cmd_host.sv
// APB-driven serial host that sends one flash command frame per start.
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_host (
    // Clock and reset.
    input wire logic CLK_SYS,
    input wire logic RESETN,
    // APB slave.
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Serial link.
    spi_link_if.host LINK
);
    import flash_cmd_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_OPC = 3'b001,
        H_ADR = 3'b011,
        H_DAT = 3'b010,
        H_FIN = 3'b110
    } host_state_t;

    logic [15:0] ctrl_r;
    logic [31:0] addr_r;
    logic [31:0] data_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    host_state_t state_r;
    logic [2:0] div_r;
    logic sck_r;
    logic cs_n_r;
    logic [3:0] io_o_r;
    logic [3:0] io_oe_r;
    logic [31:0] sh_r;
    logic [5:0] rem_r;
    logic lanes4_r;

    // APB decode; the answer comes one cycle into the access phase.
    wire sel_ctrl = (PADDR == REG_CTRL);
    wire sel_addr = (PADDR == REG_ADDR);
    wire sel_data = (PADDR == REG_DATA);
    wire sel_stat = (PADDR == REG_STATUS);
    wire mapped = sel_ctrl | sel_addr | sel_data | sel_stat;
    wire access = PSEL & PENABLE & ~pready_r;
    wire commit = PSEL & PENABLE & pready_r & PWRITE & mapped;
    wire busy = (state_r != H_IDLE);
    wire [31:0] rd_val = sel_ctrl ? {16'h0000, ctrl_r} :
        sel_addr ? addr_r : sel_data ? data_r : sel_stat ? {31'h0, busy} : 32'h0000_0000;
    // A start while a frame runs is dropped.
    wire start = commit & sel_ctrl & PWDATA[CTRL_START_BIT] & ~busy;

    wire four_lane = ctrl_r[CTRL_FOUR_LANE_BIT];
    wire addr_en = ctrl_r[CTRL_ADDR_EN_BIT];
    wire addr_long = ctrl_r[CTRL_ADDR_LONG_BIT];
    wire quad_data = ctrl_r[CTRL_QUAD_DATA_BIT];
    wire [2:0] nbytes = ctrl_r[CTRL_NBYTES_LSB +: 3];
    // Counts above four send four bytes.
    wire [5:0] data_bits = (nbytes > 3'h4) ? 6'h20 : {nbytes, 3'b000};

    wire tick = busy & (div_r == SCK_HALF_CYCLES - 3'h1);
    wire [5:0] rem_nxt = rem_r - (lanes4_r ? 6'h04 : 6'h01);
    wire [31:0] sh_shift = lanes4_r ? {sh_r[27:0], 4'h0} : {sh_r[30:0], 1'b0};
    wire host_state_t phase_nxt = (state_r == H_OPC && addr_en) ? H_ADR :
        (state_r != H_DAT && data_bits != 6'h00) ? H_DAT : H_FIN;
    wire [31:0] load_sh = (phase_nxt == H_ADR) ? (addr_long ? addr_r : {addr_r[23:0], 8'h00}) :
        data_r;
    wire [5:0] load_rem = (phase_nxt == H_ADR) ? (addr_long ? 6'h20 : 6'h18) : data_bits;
    wire load_l4 = (phase_nxt == H_ADR) ? four_lane : (quad_data | four_lane);
    wire leave = tick & sck_r & (rem_nxt == 6'h00);
    // At the start edge ctrl_r still holds the previous frame, so opcode and lanes come from the bus.
    wire [31:0] cur_sh = leave ? load_sh : (start ? {PWDATA[7:0], 24'h0} : sh_shift);
    wire cur_l4 = leave ? load_l4 : (start ? PWDATA[CTRL_FOUR_LANE_BIT] : lanes4_r);

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            ctrl_r <= CTRL_RESET;
            addr_r <= 32'h0000_0000;
            data_r <= 32'h0000_0000;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= access;
            pslverr_r <= access & ~mapped;
            prdata_r <= (access & ~PWRITE) ? rd_val : 32'h0000_0000;
            if (commit && sel_ctrl && !busy) begin
                ctrl_r <= {PWDATA[15:9], 1'b0, PWDATA[7:0]};
            end
            if (commit && sel_addr) begin
                addr_r <= PWDATA;
            end
            if (commit && sel_data) begin
                data_r <= PWDATA;
            end
        end
    end

    // Frame sequencer: bits change after the falling edge, device samples on the rise.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            state_r <= H_IDLE;
            div_r <= 3'h0;
            sck_r <= 1'b0;
            cs_n_r <= 1'b1;
            io_o_r <= 4'h0;
            io_oe_r <= 4'h0;
            sh_r <= 32'h0000_0000;
            rem_r <= 6'h00;
            lanes4_r <= 1'b0;
        end else begin
            div_r <= tick ? 3'h0 : (busy ? div_r + 3'h1 : 3'h0);
            if (start || (tick && sck_r && state_r != H_FIN)) begin
                sh_r <= cur_sh;
                lanes4_r <= cur_l4;
                io_o_r <= cur_l4 ? cur_sh[31:28] : {3'b000, cur_sh[31]};
                io_oe_r <= cur_l4 ? 4'hF : 4'h1;
            end
            if (start) begin
                state_r <= H_OPC;
                cs_n_r <= 1'b0;
                rem_r <= 6'h08;
            end else if (tick && state_r == H_FIN) begin
                state_r <= H_IDLE;
                cs_n_r <= 1'b1;
                io_oe_r <= 4'h0;
            end else if (tick && !sck_r) begin
                sck_r <= 1'b1;
            end else if (tick) begin
                sck_r <= 1'b0;
                rem_r <= leave ? load_rem : rem_nxt;
                if (leave) begin
                    state_r <= phase_nxt;
                end
            end
        end
    end

    assign PRDATA = prdata_r;
    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;
    assign LINK.sck = sck_r;
    assign LINK.cs_n = cs_n_r;
    assign LINK.io_host_o = io_o_r;
    assign LINK.io_host_oe = io_oe_r;
endmodule : flash_cmd_host
`default_nettype wire

// ===== dv/flash_quad_program_erase_cmds_assertions.sv
// Concurrent checks on the serial link and on the device's launch and status outputs.
`timescale 1ns/1ps
`default_nettype none
module flash_quad_program_erase_cmds_assertions
    import flash_cmd_pkg::*;
#(
    parameter int PROG_CYCLES = 20,
    parameter int ERASE_CYCLES = 40
) (
    // Clock and reset.
    input wire logic CLK_SYS,
    input wire logic RESETN,
    // Link.
    input wire logic sck,
    input wire logic cs_n,
    input wire logic [3:0] io_host_oe,
    // Device status and launch.
    input wire logic WRITE_UNLOCK_LATCH,
    input wire logic OPERATION_BUSY_FLAG,
    input wire logic ERASE_ERR,
    input wire logic [31:0] OP_ADDR,
    input wire flash_cmd_pkg::op_kind_t OP_KIND,
    input wire logic OP_START,
    input wire logic PB_WE
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);

    logic [15:0] busy_len_r;
    logic armed_r;

    // Armed stays set from the latch until a launch or a frame that starts without it.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            busy_len_r <= 16'h0000;
            armed_r <= 1'b0;
        end else begin
            busy_len_r <= OPERATION_BUSY_FLAG ? busy_len_r + 16'h0001 : 16'h0000;
            armed_r <= WRITE_UNLOCK_LATCH | (armed_r & cs_n & ~OP_START);
        end
    end

    sequence launch_s;
        $rose(OP_START);
    endsequence
    sequence frame_closed_s;
        cs_n && $past(cs_n, 2);
    endsequence

    chk_start_after_cs: assert property (launch_s |-> frame_closed_s)
        else $error("launch while chip select low");
    chk_busy_with_start: assert property ($rose(OPERATION_BUSY_FLAG) |-> OP_START)
        else $error("busy rose without launch");
    chk_start_one_cycle: assert property (OP_START |=> !OP_START)
        else $error("launch pulse too long");
    chk_busy_length: assert property ($fell(OPERATION_BUSY_FLAG) |->
        (busy_len_r >= 16'(PROG_CYCLES - 1) && busy_len_r <= 16'(PROG_CYCLES + 1)) ||
        (busy_len_r >= 16'(ERASE_CYCLES - 1) && busy_len_r <= 16'(ERASE_CYCLES + 1)))
        else $error("busy length wrong");
    chk_start_needs_latch: assert property (launch_s |-> armed_r || WRITE_UNLOCK_LATCH)
        else $error("launch without unlock");
    chk_latch_drops: assert property (launch_s |-> ##[0:2] !WRITE_UNLOCK_LATCH)
        else $error("latch kept after launch");
    chk_err_no_launch: assert property ($rose(ERASE_ERR) |->
        !OP_START && !OPERATION_BUSY_FLAG) else $error("error flag with launch");
    chk_chip_base: assert property (OP_START && OP_KIND == KIND_CHIP |-> OP_ADDR == 32'h0)
        else $error("chip wipe base not zero");
    chk_sector_align: assert property (OP_START && OP_KIND == KIND_SECTOR |->
        (OP_ADDR & ~SECTOR_MASK) == 32'h0) else $error("sector base misaligned");
    chk_half_align: assert property (OP_START && OP_KIND == KIND_HALF |->
        (OP_ADDR & ~HALF_MASK) == 32'h0) else $error("half block base misaligned");
    chk_block_align: assert property (OP_START && OP_KIND == KIND_BLOCK |->
        (OP_ADDR & ~BLOCK_MASK) == 32'h0) else $error("block base misaligned");
    chk_page_in_frame: assert property (PB_WE |-> !cs_n && !OPERATION_BUSY_FLAG)
        else $error("page write outside frame");
    chk_sck_rate: assert property ($rose(sck) |-> sck [*4])
        else $error("serial clock high too short");
    chk_link_idle: assert property (cs_n && $past(cs_n) |-> !sck && io_host_oe == 4'h0)
        else $error("link active outside frame");
endmodule : flash_quad_program_erase_cmds_assertions
`default_nettype wire

// ===== dv/flash_quad_program_erase_cmds_tb_top.sv
// Bench joining host and device over the link, checked against a queue model.
`timescale 1ns/1ps
`default_nettype none
module flash_quad_program_erase_cmds_tb_top;
    import flash_cmd_pkg::*;
    logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic qe, alc, four_lane, p_sec, p_half, p_blk, p_any, err_clear;
    logic latch, busy, eerr, op_start, pb_we;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, op_addr, tgt, tgt_seen;
    logic [7:0] pb_ofs, pb_data;
    op_kind_t op_kind;
    int mismatches = 0;
    int cmp_count = 0;
    int m_latch = 0;
    int m_err = 0;
    int kind_q[$];
    logic [31:0] addr_q[$];
    logic [15:0] pb_q[$];
    logic [7:0] ops[8] = '{8'h20, 8'h21, 8'h52, 8'h53, 8'hD8, 8'hDC, 8'h60, 8'hC7};
    spi_link_if link();
    flash_cmd_host u_flash_cmd_host (.CLK_SYS(clk_sys), .RESETN(resetn), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .LINK(link));
    flash_cmd_device #(.PROG_CYCLES(20), .ERASE_CYCLES(40)) u_flash_cmd_device (
        .CLK_SYS(clk_sys), .RESETN(resetn), .LINK(link), .QUAD_ENABLE(qe),
        .ADDR_LONG_CFG(alc), .FOUR_LANE_MODE(four_lane), .PROT_SECTOR(p_sec),
        .PROT_HALF(p_half), .PROT_BLOCK(p_blk), .PROT_ANY(p_any), .ERR_CLEAR(err_clear),
        .WRITE_UNLOCK_LATCH(latch), .OPERATION_BUSY_FLAG(busy), .ERASE_ERR(eerr),
        .TARGET_ADDR(tgt), .OP_ADDR(op_addr), .OP_KIND(op_kind), .OP_START(op_start),
        .PB_WE(pb_we), .PB_OFS(pb_ofs), .PB_DATA(pb_data));
    flash_quad_program_erase_cmds_assertions #(.PROG_CYCLES(20), .ERASE_CYCLES(40))
        u_flash_quad_program_erase_cmds_assertions (.CLK_SYS(clk_sys), .RESETN(resetn),
        .sck(link.sck), .cs_n(link.cs_n), .io_host_oe(link.io_host_oe),
        .WRITE_UNLOCK_LATCH(latch), .OPERATION_BUSY_FLAG(busy), .ERASE_ERR(eerr),
        .OP_ADDR(op_addr), .OP_KIND(op_kind), .OP_START(op_start), .PB_WE(pb_we));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    // Entered just after a rising edge; the request holds until ready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    function automatic int alen_of(input logic [7:0] op);
        if (op == 8'h60 || op == 8'hC7) return 0;
        return (alc || op inside {8'h34, 8'h21, 8'h53, 8'hDC}) ? 4 : 3;
    endfunction : alen_of

    // Sends one frame through the host and compares the device against the model.
    task automatic run(input logic [7:0] op, input int alen, input int nb);
        logic [31:0] a, d, m;
        int kind, ok, prot;
        a = $urandom();
        d = $urandom();
        kind_q.delete();
        addr_q.delete();
        pb_q.delete();
        apb(1'b1, REG_ADDR, a);
        apb(1'b1, REG_DATA, d);
        apb(1'b1, REG_CTRL, {16'h0000, 3'(nb), 1'b1, alen == 4, alen != 0, four_lane, 1'b1, op});
        do begin
            apb(1'b0, REG_STATUS, 32'h0);
        end while (rd[0] !== 1'b0);
        repeat (8) @(posedge clk_sys);
        if (alen == 3) a[31:24] = 8'h00;
        kind = op inside {8'h32, 8'h34} ? 1 : op inside {8'h20, 8'h21} ? 2 :
            op inside {8'h52, 8'h53} ? 3 : op inside {8'hD8, 8'hDC} ? 4 : op inside {8'h60, 8'hC7} ? 5 : 0;
        prot = kind == 2 ? p_sec : kind == 3 ? p_half : kind == 4 ? p_blk : p_any;
        m = kind == 2 ? SECTOR_MASK : kind == 3 ? HALF_MASK : kind == 4 ? BLOCK_MASK : kind == 5 ? 32'h0 : 32'hFFFF_FFFF;
        ok = 0;
        if (op == 8'h06 && alen == 0 && nb == 0) m_latch = 1;
        if (kind == 1) ok = m_latch && qe && nb > 0 && alen == alen_of(op);
        if (kind > 1 && m_latch) begin
            ok = alen == alen_of(op) && nb == 0 && !prot;
            m_err = m_err | (alen == alen_of(op) && nb == 0 && prot);
        end
        if (kind != 0) m_latch = 0;
        check(kind_q.size(), ok);
        check(busy, ok);
        if (ok && kind_q.size() > 0) begin
            check(kind_q[0], kind);
            check(addr_q[0], a & m);
        end
        for (int i = 0; i < (ok && kind == 1 ? nb : 0); i++)
            check(pb_q[i], {a[7:0] + 8'(i), d[31 - 8 * i -: 8]});
        check(pb_q.size(), ok && kind == 1 ? nb : 0);
        if (ok && kind == 1) check(tgt_seen, a);
        check(latch, m_latch);
        check(eerr, m_err);
        while (busy !== 1'b0) begin
            @(posedge clk_sys);
        end
    endtask : run

    always @(posedge clk_sys) begin
        if (op_start === 1'b1) begin
            kind_q.push_back(int'(op_kind));
            addr_q.push_back(op_addr);
        end
        if (pb_we === 1'b1) pb_q.push_back({pb_ofs, pb_data});
        if (pb_we === 1'b1) tgt_seen = tgt;
    end

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // About 10000 cycles are expected; eight times that means a hang.
    initial begin
        #1_600_000;
        mismatches++;
        stop_test();
    end

    initial begin
        {resetn, psel, penable, pwrite, qe, alc, four_lane, err_clear} = 8'h00;
        {p_sec, p_half, p_blk, p_any} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        void'($urandom(57162));
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        apb(1'b0, REG_CTRL, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, 12'h010, 32'hFFFF_FFFF);
        check(rerr, 1'b1);
        $display("test register map done");
        qe <= 1'b1;
        for (int lane = 0; lane < 2; lane++) begin
            for (int i = 0; i < 8; i++) begin
                four_lane <= lane[0];
                alc <= 1'($urandom_range(1, 0));
                @(posedge clk_sys);
                run(8'h06, 0, 0);
                run(ops[i], alen_of(ops[i]), 0);
            end
            for (int nb = 0; nb < 5; nb++) begin
                run(8'h06, 0, 0);
                run(nb[0] ? 8'h34 : 8'h32, alen_of(nb[0] ? 8'h34 : 8'h32), nb);
            end
        end
        $display("test wipes and quad writes done");
        run(8'h20, alen_of(8'h20), 0);
        run(8'h06, 0, 0);
        run(8'h21, 3, 0);
        run(8'h06, 0, 0);
        run(8'h60, 3, 0);
        qe <= 1'b0;
        @(posedge clk_sys);
        run(8'h06, 0, 0);
        run(8'h32, alen_of(8'h32), 2);
        for (int k = 0; k < 4; k++) begin
            {p_any, p_blk, p_half, p_sec} <= 4'h1 << k;
            @(posedge clk_sys);
            run(8'h06, 0, 0);
            run(ops[2 * k], alen_of(ops[2 * k]), 0);
            err_clear <= 1'b1;
            @(posedge clk_sys);
            err_clear <= 1'b0;
            m_err = 0;
            repeat (2) @(posedge clk_sys);
            check(eerr, m_err);
        end
        $display("test refusals done");
        stop_test();
    end
endmodule : flash_quad_program_erase_cmds_tb_top
`default_nettype wire
